// ---- core/hsw_ctrl.sv ----
`timescale 1ns/10ps
// What this block does
// - HALT gates CPU clock, oscillator and peripherals run
// - HALT ends only on a taken interrupt or a watchdog expiry
// - after HALT, resume at following instruction
// - STOP halts CPU clock and oscillator
// - low recovery pin releases STOP without asserting reset
// - pin releases STOP even when an output
// - STOP release restarts at address 000C
// - port mode registers kept over pin recovery
// - first 5F arms watchdog, later ones clear
// - no instruction stops an armed watchdog
// - missed refresh expires watchdog into reset
// - watchdog opcode sets Z, clears S, V
// - watchdog reset lasts POR delay plus 18
// - software watchdog frozen during STOP
// - 4F keeps watchdog running in HALT
// - 4F ignored until watchdog armed
// - permanent option: armed at reset, always runs
// - watchdog timeout at least 12 ms
module hsw_ctrl #(
  parameter int WDT_CYCLES = hsw_pkg::WDT_CYCLES,
  parameter int WDT_W      = 18,
  parameter int POR_CYCLES = hsw_pkg::POR_CYCLES,
  parameter int RST_W      = 8
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // instruction decoder and interrupt logic
  input  wire hsw_pkg::hsw_op_type   cpu_op,
  input  wire logic                  irq_taken,
  output hsw_pkg::hsw_flag_type      flag_out,
  output logic                       restart_load,
  output logic [15:0]                restart_addr,
  // clock control and reset generator
  output logic                       cpu_clk_en,
  output logic                       osc_en,
  output logic                       periph_clk_en,
  output logic                       sys_reset_n,
  // pins and options
  input  wire logic                  stop_recovery_pin,
  input  wire logic                  permanent_wdt_option,
  output logic [7:0]                 port2_direction_config
);

  localparam int RST_CYCLES = POR_CYCLES + hsw_pkg::RST_EXTRA_CYCLES;
  localparam logic [RST_W-1:0] RST_LOAD = RST_W'(RST_CYCLES);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);

  hsw_pkg::hsw_state_type state;
  hsw_pkg::hsw_state_type next_state;
  logic             pin_s1;
  logic             pin_s2;
  logic             perm_s1;
  logic             perm_s2;
  logic [1:0]       init_cnt;
  logic             perm_cap;
  logic             wdt_en;
  logic             halt_keep;
  logic [WDT_W-1:0] wdt_cnt;
  logic [RST_W-1:0] rst_cnt;
  logic [RST_W-1:0] next_rst_cnt;
  logic             wdt_reset_seen;

  function automatic logic is_op(input hsw_pkg::hsw_op_type op,
                                 input logic [7:0] code);
    return op.exec && (op.opcode == code);
  endfunction : is_op

  // decode
  wire in_rst    = (rst_cnt != '0);
  wire st_run    = (state == hsw_pkg::HSW_RUN);
  wire st_halt   = (state == hsw_pkg::HSW_HALT);
  wire st_stop   = (state == hsw_pkg::HSW_STOP);
  // the gated CPU cannot issue opcodes outside RUN
  wire op_ok     = st_run && !in_rst;
  wire do_wdt    = op_ok && is_op(cpu_op, hsw_pkg::OP_WDT);
  wire do_wdh    = op_ok && is_op(cpu_op, hsw_pkg::OP_WDH);
  wire do_stop   = op_ok && is_op(cpu_op, hsw_pkg::OP_STOP);
  wire do_halt   = op_ok && is_op(cpu_op, hsw_pkg::OP_HALT);
  // pin level is read regardless of port direction
  wire pin_wake  = st_stop && !pin_s2;
  // pclk is the crystal, never gated by this block
  wire wdt_tick  = wdt_en && !in_rst &&
                   (st_run ||
                    (st_halt && (halt_keep || perm_cap)) ||
                    (st_stop && perm_cap));
  wire wdt_fire  = wdt_tick && (wdt_cnt == WDT_LAST);
  wire refresh   = do_wdt && wdt_en;

  wire acc       = psel && penable;
  wire hit_stat  = (paddr == hsw_pkg::REG_STATUS);
  wire hit_p2    = (paddr == hsw_pkg::REG_PORT2_DIR);
  wire hit_cnt   = (paddr == hsw_pkg::REG_WDT_COUNT);
  wire hit_any   = hit_stat || hit_p2 || hit_cnt;
  wire wr_p2     = acc && pready && pwrite && hit_p2;

  wire [31:0] status_word = {24'h000000,
    port2_direction_config[hsw_pkg::PORT2_RECOVERY_BIT],
    wdt_reset_seen, perm_cap, halt_keep, wdt_en, state};
  wire [31:0] read_mux =
    hit_stat ? status_word :
    hit_p2   ? {24'h000000, port2_direction_config} :
    hit_cnt  ? 32'(wdt_cnt) : 32'h00000000;

  always_comb begin
    next_state = state;
    unique case (state)
      hsw_pkg::HSW_RUN: begin
        if (do_stop) begin
          next_state = hsw_pkg::HSW_STOP;
        end else if (do_halt) begin
          next_state = hsw_pkg::HSW_HALT;
        end
      end
      hsw_pkg::HSW_HALT: begin
        if (irq_taken) begin
          next_state = hsw_pkg::HSW_RUN;
        end
      end
      hsw_pkg::HSW_STOP: begin
        if (pin_wake) begin
          next_state = hsw_pkg::HSW_RUN;
        end
      end
    endcase
    if (wdt_fire || in_rst) begin
      next_state = hsw_pkg::HSW_RUN;
    end
  end

  always_comb begin
    if (wdt_fire) begin
      next_rst_cnt = RST_LOAD;
    end else if (in_rst) begin
      next_rst_cnt = rst_cnt - RST_W'(1);
    end else begin
      next_rst_cnt = '0;
    end
  end

  // two-flop synchronisers for pin and option strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1  <= 1'h1;
      pin_s2  <= 1'h1;
      perm_s1 <= 1'h0;
      perm_s2 <= 1'h0;
    end else begin
      pin_s1  <= stop_recovery_pin;
      pin_s2  <= pin_s1;
      perm_s1 <= permanent_wdt_option;
      perm_s2 <= perm_s1;
    end
  end

  // option is a fuse: caught once, after the synchroniser settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt <= 2'h0;
      perm_cap <= 1'h0;
    end else if (init_cnt != 2'h3) begin
      init_cnt <= init_cnt + 2'h1;
      perm_cap <= perm_s2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= hsw_pkg::HSW_RUN;
      cpu_clk_en    <= 1'h1;
      osc_en        <= 1'h1;
      periph_clk_en <= 1'h1;
      rst_cnt       <= '0;
      sys_reset_n   <= 1'h1;
      restart_load  <= 1'h0;
      restart_addr  <= hsw_pkg::RESTART_ADDR;
      flag_out      <= '0;
    end else begin
      state         <= next_state;
      cpu_clk_en    <= (next_state == hsw_pkg::HSW_RUN);
      osc_en        <= (next_state != hsw_pkg::HSW_STOP);
      periph_clk_en <= (next_state != hsw_pkg::HSW_STOP);
      rst_cnt       <= next_rst_cnt;
      sys_reset_n   <= (next_rst_cnt == '0);
      // HALT exit loads nothing: the stacked PC is the next one
      restart_load  <= pin_wake;
      restart_addr  <= hsw_pkg::RESTART_ADDR;
      flag_out      <= {do_wdt, 1'h1, 1'h0, 1'h0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_en         <= 1'h0;
      halt_keep      <= 1'h0;
      wdt_cnt        <= '0;
      wdt_reset_seen <= 1'h0;
    end else begin
      if (wdt_fire) begin
        wdt_en <= perm_cap;
      end else if (perm_cap || do_wdt) begin
        wdt_en <= 1'h1;
      end
      if (wdt_fire) begin
        halt_keep <= 1'h0;
      end else if (do_wdh && wdt_en) begin
        halt_keep <= 1'h1;
      end
      if (wdt_fire || refresh) begin
        wdt_cnt <= '0;
      end else if (wdt_tick) begin
        wdt_cnt <= wdt_cnt + WDT_W'(1);
      end
      if (wdt_fire) begin
        wdt_reset_seen <= 1'h1;
      end
    end
  end

  // apb: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready                 <= 1'h0;
      prdata                 <= 32'h00000000;
      pslverr                <= 1'h0;
      port2_direction_config <= hsw_pkg::PORT2_DIR_RESET;
    end else begin
      pready  <= acc && !pready;
      prdata  <= (acc && !pready && !pwrite) ? read_mux : 32'h00000000;
      pslverr <= acc && !pready && !hit_any;
      // stop recovery never touches this register
      if (wr_p2) begin
        port2_direction_config <= pwdata[7:0];
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [RST_W:0] low_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_len <= '0;
    end else begin
      low_len <= sys_reset_n ? '0 : low_len + (RST_W+1)'(1);
    end
  end

  sequence s_stop_low;
    st_stop && !pin_s2 && !in_rst;
  endsequence
  sequence s_restart;
    restart_load && (restart_addr == 16'h000C) && cpu_clk_en && osc_en;
  endsequence

  property p_halt_gate;
    st_halt |-> !cpu_clk_en && osc_en && periph_clk_en;
  endproperty
  a_halt_gate: assert property (p_halt_gate)
    else $error("halt clock gating wrong");

  property p_halt_hold;
    st_halt && !irq_taken && !wdt_fire |=> st_halt && !cpu_clk_en;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halt left without interrupt");

  property p_halt_exit;
    st_halt && irq_taken |=> st_run && cpu_clk_en && !restart_load;
  endproperty
  a_halt_exit: assert property (p_halt_exit)
    else $error("halt exit wrong");

  property p_stop_osc;
    st_stop |-> !osc_en && !cpu_clk_en && !periph_clk_en;
  endproperty
  a_stop_osc: assert property (p_stop_osc)
    else $error("stop left a clock running");

  property p_stop_release;
    s_stop_low |=> s_restart ##1 !restart_load;
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("stop release or restart vector wrong");

  property p_port_keep;
    $rose(restart_load) |-> $stable(port2_direction_config);
  endproperty
  a_port_keep: assert property (p_port_keep)
    else $error("port mode changed by recovery");

  property p_arm;
    do_wdt && !wdt_en |=> wdt_en && (wdt_cnt == '0);
  endproperty
  a_arm: assert property (p_arm)
    else $error("watchdog not armed");

  property p_no_disarm;
    wdt_en && !wdt_fire |=> wdt_en;
  endproperty
  a_no_disarm: assert property (p_no_disarm)
    else $error("watchdog stopped");

  property p_flags;
    do_wdt |=> flag_out.update && flag_out.zero && !flag_out.sign
               && !flag_out.ovf;
  endproperty
  a_flags: assert property (p_flags)
    else $error("watchdog flags wrong");

  property p_rst_len;
    $rose(sys_reset_n) |-> (low_len == (RST_W+1)'(RST_CYCLES));
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("watchdog reset length wrong");

  property p_stop_freeze;
    st_stop && !perm_cap |=> $stable(wdt_cnt);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze)
    else $error("software watchdog counted in stop");

  property p_wdh_gate;
    do_wdh && !wdt_en && !halt_keep |=> !halt_keep;
  endproperty
  a_wdh_gate: assert property (p_wdh_gate)
    else $error("keep opcode acted before arming");

endmodule : hsw_ctrl

// ---- core/hsw_pkg.sv ----
package hsw_pkg;

  // clock and timing
  localparam int CLK_HZ            = 20_000_000;
  localparam int CLK_PERIOD_NS     = 50;
  localparam int WDT_TIMEOUT_MS    = 12;
  localparam int WDT_CYCLES        = WDT_TIMEOUT_MS * (CLK_HZ / 1000);
  // reset delay has no printed figure here; plain default
  localparam int POR_DELAY_NS      = 1000;
  localparam int POR_CYCLES        =
    (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_EXTRA_CYCLES  = 18;

  // opcodes seen from the instruction decoder
  localparam logic [7:0] OP_NOP    = 8'hFF;
  localparam logic [7:0] OP_STOP   = 8'h6F;
  localparam logic [7:0] OP_HALT   = 8'h7F;
  localparam logic [7:0] OP_WDT    = 8'h5F;
  localparam logic [7:0] OP_WDH    = 8'h4F;

  localparam logic [15:0] RESTART_ADDR = 16'h000C;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_PORT2_DIR = 8'h04;
  localparam logic [7:0] REG_WDT_COUNT = 8'h08;

  localparam logic [7:0] PORT2_DIR_RESET = 8'hFF;
  localparam int PORT2_RECOVERY_BIT      = 7;

  // status fields
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_WDT_EN     = 3;
  localparam int ST_HALT_KEEP  = 4;
  localparam int ST_PERMANENT  = 5;
  localparam int ST_WDT_RESET  = 6;
  localparam int ST_PIN_INPUT  = 7;

  typedef enum logic [2:0] {
    HSW_RUN  = 3'b001,
    HSW_HALT = 3'b010,
    HSW_STOP = 3'b100
  } hsw_state_type;

  typedef struct packed {
    logic       exec;
    logic [7:0] opcode;
  } hsw_op_type;

  typedef struct packed {
    logic update;
    logic zero;
    logic sign;
    logic ovf;
  } hsw_flag_type;

endpackage : hsw_pkg

// ---- dv/hsw_cpu_model.sv ----
`timescale 1ns/10ps
module hsw_cpu_model (
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // bench requests
  input  wire logic [7:0]     req_op,
  input  wire logic           req_go,
  input  wire logic           req_irq,
  // design side
  input  wire logic           cpu_clk_en,
  input  wire logic           restart_load,
  input  wire logic [15:0]    restart_addr,
  output hsw_pkg::hsw_op_type cpu_op,
  output logic                irq_taken,
  output logic [15:0]         pc
);
  // a gated core cannot fetch, so nothing issues while the clock is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_op    <= '0;
      irq_taken <= 1'b0;
      pc        <= 16'h0000;
    end else begin
      cpu_op.exec   <= req_go & cpu_clk_en;
      cpu_op.opcode <= req_op;
      irq_taken     <= req_irq;
      if (restart_load) pc <= restart_addr;
      else if (req_go & cpu_clk_en) pc <= pc + 16'h0001;
    end
  end
endmodule : hsw_cpu_model

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  // short watchdog keeps the run brief; reset length is the 20-cycle POR plus 18
  localparam int WDC = 64;
  localparam int RSTLEN = 20 + hsw_pkg::RST_EXTRA_CYCLES;
  localparam logic [7:0] AS = hsw_pkg::REG_STATUS;
  localparam logic [7:0] AP = hsw_pkg::REG_PORT2_DIR;
  localparam logic [7:0] AC = hsw_pkg::REG_WDT_COUNT;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } hsw_row_type;
  localparam hsw_row_type ROWS [10] = '{
    '{1'b0, AP, 32'h0, 32'hFF, 1'b0},
    '{1'b1, AP, 32'h5A, 32'h0, 1'b0},
    '{1'b0, AP, 32'h0, 32'h5A, 1'b0},
    '{1'b0, AS, 32'h0, 32'h1, 1'b0},
    '{1'b1, AS, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{1'b0, AS, 32'h0, 32'h1, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h10, 32'h1, 32'h0, 1'b1},
    '{1'b1, AP, 32'h12345680, 32'h0, 1'b0},
    '{1'b0, AP, 32'h0, 32'h80, 1'b0}
  };
  localparam logic [7:0] DIRS [2] = '{8'h80, 8'h00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, port2, req_op;
  logic [31:0] pwdata, prdata, r, a0;
  logic [15:0] restart_addr, pc, pcs;
  logic        irq_taken, restart_load, cpu_clk_en, osc_en, periph_clk_en;
  logic        sys_reset_n, rec_pin, perm_opt, req_go, req_irq, err;
  int          miscompares, check_count, wt;
  hsw_pkg::hsw_op_type   cpu_op;
  hsw_pkg::hsw_flag_type flag_out, fl;
  wire [2:0]   ens = {cpu_clk_en, osc_en, periph_clk_en};

  hsw_ctrl #(.WDT_CYCLES(WDC), .WDT_W(7), .POR_CYCLES(20)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cpu_op(cpu_op),
    .irq_taken(irq_taken), .flag_out(flag_out),
    .restart_load(restart_load), .restart_addr(restart_addr),
    .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
    .periph_clk_en(periph_clk_en), .sys_reset_n(sys_reset_n),
    .stop_recovery_pin(rec_pin), .permanent_wdt_option(perm_opt),
    .port2_direction_config(port2));
  hsw_cpu_model cpu_u (
    .pclk(pclk), .presetn(presetn), .req_op(req_op), .req_go(req_go),
    .req_irq(req_irq), .cpu_clk_en(cpu_clk_en),
    .restart_load(restart_load), .restart_addr(restart_addr),
    .cpu_op(cpu_op), .irq_taken(irq_taken), .pc(pc));

  always #25 pclk = ~pclk;

  task automatic results;
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task automatic give_up(input string nm);
    miscompares++;
    $display("unexpected wait %s: expected end seen none", nm);
    results();
  endtask : give_up

  task automatic chk(input string nm, input logic [31:0] ex, got);
    check_count++;
    if (got !== ex) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // request held until pready is seen, then one idle edge before the next
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) give_up("pready");
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic op(input logic [7:0] c);
    req_op <= c;
    req_go <= 1'b1;
    @(posedge pclk);
    req_go <= 1'b0;
    repeat (2) @(posedge pclk);
    fl = flag_out;
  endtask : op

  task automatic enter(input logic [7:0] c);
    op(hsw_pkg::OP_NOP);
    op(c);
  endtask : enter

  task automatic wake;
    req_irq <= 1'b1;
    @(posedge pclk);
    req_irq <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : wake

  task automatic wait_bite;
    int n;
    n = 0;
    while (sys_reset_n !== 1'b0) begin
      @(posedge pclk);
      n++;
      if (n > 300) give_up("bite");
    end
    n = 0;
    while (sys_reset_n === 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("reset length", RSTLEN, n);
  endtask : wait_bite

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {req_go, req_irq, req_op, perm_opt} = '0;
    rec_pin = 1'b1;
    miscompares = 0;
    check_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("reset enables", 3'b111, ens);
    chk("reset line", 1'b1, sys_reset_n);
    chk("restart addr", 16'h000C, restart_addr);
    chk("timeout floor", 1'b1, hsw_pkg::WDT_CYCLES >= 12 * 20000);
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d, r);
      chk("prdata", ROWS[i].q, r);
      chk("pslverr", ROWS[i].e, err);
    end
    op(hsw_pkg::OP_WDH);
    apb(1'b0, AS, 32'h0, r);
    chk("status unarmed", 32'h81, r);
    enter(hsw_pkg::OP_HALT);
    chk("halt enables", 3'b011, ens);
    repeat (10) @(posedge pclk);
    pcs = pc;
    chk("halt held", 3'b011, ens);
    wake();
    chk("woken", 3'b111, ens);
    chk("resume pc", pcs, pc);
    // second pass leaves the recovery pin configured as an output
    foreach (DIRS[i]) begin
      apb(1'b1, AP, {24'h0, DIRS[i]}, r);
      enter(hsw_pkg::OP_STOP);
      chk("stop enables", 3'b000, ens);
      rec_pin <= 1'b0;
      wt = 0;
      while (restart_load !== 1'b1) begin
        @(posedge pclk);
        wt++;
        if (wt > 20) give_up("restart");
      end
      chk("restart addr", 16'h000C, restart_addr);
      rec_pin <= 1'b1;
      @(posedge pclk);
      chk("restart pc", 16'h000C, pc);
      chk("recovered", 3'b111, ens);
      apb(1'b0, AP, 32'h0, r);
      chk("port2 kept", DIRS[i], r);
      chk("port2 output", DIRS[i], port2);
    end
    op(hsw_pkg::OP_WDT);
    chk("flags", 4'b1100, fl);
    apb(1'b0, AS, 32'h0, r);
    chk("armed", 1'b1, r[hsw_pkg::ST_WDT_EN]);
    enter(hsw_pkg::OP_HALT);
    apb(1'b0, AC, 32'h0, a0);
    apb(1'b0, AC, 32'h0, r);
    chk("paused count", a0, r);
    wake();
    op(hsw_pkg::OP_WDH);
    op(hsw_pkg::OP_WDT);
    apb(1'b0, AC, 32'h0, r);
    chk("cleared", 1'b1, r < 32'h8);
    enter(hsw_pkg::OP_HALT);
    apb(1'b0, AC, 32'h0, a0);
    apb(1'b0, AC, 32'h0, r);
    chk("halt count", a0 + 32'h4, r);
    wake();
    wait_bite();
    apb(1'b0, AS, 32'h0, r);
    chk("after bite", 32'h41, r & 32'h7F);
    op(hsw_pkg::OP_WDT);
    enter(hsw_pkg::OP_STOP);
    apb(1'b0, AC, 32'h0, a0);
    repeat (100) @(posedge pclk);
    apb(1'b0, AC, 32'h0, r);
    chk("stop count", a0, r);
    chk("no bite", 1'b1, sys_reset_n);
    rec_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    rec_pin <= 1'b1;
    perm_opt <= 1'b1;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, AS, 32'h0, r);
    chk("permanent status", 32'hA9, r);
    enter(hsw_pkg::OP_STOP);
    wait_bite();
    chk("run after bite", 3'b111, ens);
    apb(1'b0, AS, 32'h0, r);
    chk("permanent after bite", 32'hE9, r);
    results();
  end
endmodule : testbench
